/* inc/owc_pkg.sv */
package owc_pkg;
    // Option word layout
    localparam int OWC_WORD_W = 15;
    localparam int OWC_SRC_SEL_BIT = 14;
    localparam int OWC_START_MODE_BIT = 10;
    localparam int OWC_LVL_HI_BIT = 8;
    localparam int OWC_LVL_LO_BIT = 7;
    localparam int OWC_RST_PIN_BIT = 6;
    localparam int OWC_WDT_DIS_BIT = 5;
    localparam int OWC_NR_LEN_BIT = 4;
    localparam int OWC_NR_ON_BIT = 3;
    localparam int OWC_PROT_HI_BIT = 2;
    localparam int OWC_SUB_FREQ_BIT = 13;
    localparam int OWC_RC_HI_BIT = 6;
    localparam int OWC_RC_LO_BIT = 5;
    localparam int OWC_CLK_ROLE_BIT = 1;
    localparam int OWC_CYC_OUT_BIT = 0;
    // Reset values of the option words (erased defaults)
    localparam logic [14:0] OWC_WORD0_RST = 15'h7DDF;
    localparam logic [14:0] OWC_WORD1_RST = 15'h7FBF;
    // Field encodings
    localparam logic [2:0] OWC_PROT_ON = 3'h0;
    localparam logic [1:0] OWC_LVL_OFF = 2'h3;
    localparam logic [1:0] OWC_LVL_2V7 = 2'h2;
    localparam logic [1:0] OWC_LVL_3V5 = 2'h1;
    localparam logic [1:0] OWC_LVL_4V0 = 2'h0;
    localparam logic [1:0] OWC_RC_8M = 2'h1;
    localparam logic [1:0] OWC_RC_16M = 2'h2;
    localparam logic [1:0] OWC_RC_4M = 2'h3;
    localparam logic [1:0] OWC_RC_BAD = 2'h0;
    // Mirror register reset value
    localparam logic [7:0] OWC_MIRROR_RST = 8'h00;
    // Timing
    localparam int OWC_CLK_MHZ = 250;
    localparam int OWC_DIP_NS = 5000;
    localparam int OWC_DIP_CYC = (OWC_DIP_NS * OWC_CLK_MHZ + 999) / 1000;
    localparam int OWC_NR_SHORT_CYC = 8;
    localparam int OWC_NR_LONG_CYC = 32;
    localparam int OWC_WDT_DIV = OWC_CLK_MHZ * 1000 / 16;
    localparam int OWC_SUB16_DIV = OWC_CLK_MHZ * 1000 / 16;
    localparam int OWC_SUB64_DIV = OWC_CLK_MHZ * 1000 / 64;
    // Mirror register selects
    localparam logic [1:0] OWC_MIR_A = 2'h0;
    localparam logic [1:0] OWC_MIR_B = 2'h1;
    localparam logic [1:0] OWC_MIR_C = 2'h2;
    // Loader states, Gray order
    typedef enum logic [1:0] {
        OWC_ST_IDLE  = 2'b00,
        OWC_ST_LATCH = 2'b01,
        OWC_ST_RUN   = 2'b11
    } owc_state_t;
endpackage

/* src/owc_option_latch.sv */
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
// Behaviour
// R1 - Word0 bit 14 picks mirrored bits: 0 from control registers, 1 from option word.
// R2 - Latch options first at power-on; with source 0 preload mirrors, software may overwrite.
// R3 - Word0 bit 10 selects start mode after any reset: 0 green, 1 normal.
// R4 - Two-bit level field: 11 off, 10 2.7V, 01 3.5V, 00 4.0V.
// R5 - Low-voltage reset fires only after supply stays low about 5 us.
// R6 - Word0 bit 6: 0 shared pin is reset input, 1 port and interrupt.
// R7 - Word0 bit 5: 0 enables watchdog, 1 disables it.
// R8 - Word0 bit 4: 0 accepts 8-period pulses, 1 accepts 32-period pulses.
// R9 - Word0 bit 3: 0 disables noise filter, 1 enables it.
// R10 - Noise filter forced off in green, idle and sleep modes.
// R11 - Protect field 000 enables code protection, 111 disables it.
// R12 - Word1 bit 13 selects sub clock: 0 gives 64 kHz, 1 gives 16 kHz.
// R13 - Watchdog clock is always 16 kHz regardless of sub clock selection.
// R14 - Word1 bits 6-5: 01 8 MHz, 10 16 MHz, 11 4 MHz, 00 invalid.
// R15 - Word1 bit 1: 1 clock pin is general I/O, 0 clock output.
// R16 - Word1 bit 0: 0 oscillator pin open drain, 1 drives cycle clock.
// R17 - Programmer fills unused option bits with their fixed values.
// R18 - Latched options stay fixed until next power-on; other resets leave them.
module owc_option_latch
    import owc_pkg::*;
(
    // Clock and power-on reset
    input  wire logic                        clk,
    input  wire logic                        reset_n,
    // Option word array
    input  wire logic [owc_pkg::OWC_WORD_W-1:0] opt_word0,
    input  wire logic [owc_pkg::OWC_WORD_W-1:0] opt_word1,
    // System status
    input  wire logic                        sys_reset,
    input  wire logic                        low_power_mode,
    input  wire logic [3:0]                  vdd_below,
    // Mirror register port
    input  wire logic [1:0]                  mir_addr,
    input  wire logic [7:0]                  mir_wdata,
    input  wire logic                        mir_wr,
    input  wire logic                        mir_rd,
    output logic [7:0]                       mir_rdata,
    // Distributed settings
    output logic                             options_valid,
    output logic [7:0]                       mirror_ctrl_a,
    output logic [7:0]                       mirror_ctrl_b,
    output logic [7:0]                       mirror_ctrl_c,
    output logic                             reset_start_mode_select,
    output logic                             lowvolt_reset,
    output logic                             reset_pin_select,
    output logic                             watchdog_run,
    output logic                             noise_filter_on,
    output logic [5:0]                       noise_min_cycles,
    output logic                             protect_on,
    output logic                             sub_clock_freq_sel,
    output logic                             sub_clock_tick,
    output logic                             watchdog_tick,
    output logic [1:0]                       rc_freq_sel,
    output logic                             rc_freq_invalid,
    output logic                             clock_pin_role_sel,
    output logic                             cycle_clock_out_en
);
    import owc_pkg::*;

    owc_state_t                 state_q;
    owc_state_t                 state_d;
    logic [OWC_WORD_W-1:0]      word0_q;
    logic [OWC_WORD_W-1:0]      word1_q;
    logic [7:0]                 ctrl_q [3];
    logic [7:0]                 mir_q [3];
    logic [15:0]                dip_q;
    logic [19:0]                wdt_div_q;
    logic [19:0]                sub_div_q;
    logic [7:0]                 rdata_q;
    logic                       lv_q;
    logic                       wdt_tick_q;
    logic                       sub_tick_q;
    logic                       run_q;
    logic                       mode_q;
    logic                       pin_sel_q;
    logic                       wdt_run_q;
    logic                       nr_on_q;
    logic [5:0]                 nr_min_q;
    logic                       prot_q;
    logic                       sub_sel_q;
    logic [1:0]                 rc_q;
    logic                       rc_bad_q;
    logic                       clk_role_q;
    logic                       cyc_out_q;

    // Decode
    wire        latching  = (state_q == OWC_ST_LATCH);
    wire        running   = (state_q == OWC_ST_RUN);
    wire        src_opt   = word0_q[OWC_SRC_SEL_BIT];
    wire [1:0]  lvl_sel   = {word0_q[OWC_LVL_HI_BIT], word0_q[OWC_LVL_LO_BIT]};
    wire [1:0]  rc_sel    = {word1_q[OWC_RC_HI_BIT], word1_q[OWC_RC_LO_BIT]};
    wire [2:0]  prot_code = word0_q[OWC_PROT_HI_BIT:0];
    wire        lv_below  = (lvl_sel == OWC_LVL_2V7) ? vdd_below[2] :
                            (lvl_sel == OWC_LVL_3V5) ? vdd_below[1] :
                            (lvl_sel == OWC_LVL_4V0) ? vdd_below[0] : 1'b0; // see R4
    wire        dip_done  = (dip_q >= 16'(OWC_DIP_CYC - 1));
    wire        wdt_wrap  = (wdt_div_q == 20'(OWC_WDT_DIV - 1));
    wire [19:0] sub_top   = word1_q[OWC_SUB_FREQ_BIT] ? 20'(OWC_SUB16_DIV - 1)
                                                       : 20'(OWC_SUB64_DIV - 1); // see R12
    wire        sub_wrap  = (sub_div_q >= sub_top);
    wire [7:0]  opt_bits [3];
    // The three mirrors carry the low byte of word0, the low byte of word1, and word0 high bits
    assign opt_bits[0] = word0_q[7:0];
    assign opt_bits[1] = word1_q[7:0];
    assign opt_bits[2] = {1'b0, word0_q[14:8]};

    // Loader sequence: one pass only after power-on, so later resets never reload
    always_comb begin
        case (state_q)
            OWC_ST_IDLE:  state_d = OWC_ST_LATCH;
            OWC_ST_LATCH: state_d = OWC_ST_RUN;
            OWC_ST_RUN:   state_d = OWC_ST_RUN;
            default:      state_d = OWC_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= OWC_ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Option words are caught once, first of all; sys_reset is not looked at here
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            word0_q <= OWC_WORD0_RST;
            word1_q <= OWC_WORD1_RST;
        end else if (latching) begin // see R2, R18
            word0_q <= opt_word0;
            word1_q <= opt_word1;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_mirror
            wire wr_hit = running && mir_wr && (mir_addr == 2'(gi));
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    ctrl_q[gi] <= OWC_MIRROR_RST;
                end else if (state_q == OWC_ST_IDLE) begin
                    ctrl_q[gi] <= OWC_MIRROR_RST;
                end else if (latching) begin
                    ctrl_q[gi] <= (gi == 0) ? opt_word0[7:0] :
                                  (gi == 1) ? opt_word1[7:0] : {1'b0, opt_word0[14:8]}; // see R2
                end else if (wr_hit) begin
                    ctrl_q[gi] <= mir_wdata; // see R2
                end
            end
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    mir_q[gi] <= OWC_MIRROR_RST;
                end else begin
                    mir_q[gi] <= src_opt ? opt_bits[gi] : ctrl_q[gi]; // see R1
                end
            end
        end
    endgenerate

    // Read port: data one cycle after the strobe; unused select reads zero
    wire [7:0] rd_mux = (mir_addr == OWC_MIR_A) ? mir_q[0] :
                        (mir_addr == OWC_MIR_B) ? mir_q[1] :
                        (mir_addr == OWC_MIR_C) ? mir_q[2] : 8'h00;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= mir_rd ? rd_mux : 8'h00;
        end
    end

    // Supply dip must persist before reset; a short dip restarts the count
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dip_q <= 16'h0000;
            lv_q  <= 1'b0;
        end else begin
            if (!running || !lv_below) begin
                dip_q <= 16'h0000; // see R5
            end else if (!dip_done) begin
                dip_q <= dip_q + 16'h0001;
            end
            lv_q <= running && lv_below && dip_done; // see R5
        end
    end

    // Watchdog time base runs from its own divider at a fixed rate
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wdt_div_q  <= 20'h0_0000;
            wdt_tick_q <= 1'b0;
        end else begin
            wdt_div_q  <= wdt_wrap ? 20'h0_0000 : wdt_div_q + 20'h0_0001; // see R13
            wdt_tick_q <= wdt_wrap;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sub_div_q  <= 20'h0_0000;
            sub_tick_q <= 1'b0;
        end else begin
            sub_div_q  <= sub_wrap ? 20'h0_0000 : sub_div_q + 20'h0_0001; // see R12
            sub_tick_q <= sub_wrap;
        end
    end

    // Next values of the distributed settings
    wire        mode_d     = word0_q[OWC_START_MODE_BIT]; // see R3
    wire        pin_sel_d  = word0_q[OWC_RST_PIN_BIT]; // see R6
    wire        wdt_run_d  = running && !word0_q[OWC_WDT_DIS_BIT]; // see R7
    wire        nr_on_d    = running && word0_q[OWC_NR_ON_BIT] && !low_power_mode; // see R9, R10
    wire [5:0]  nr_min_d   = word0_q[OWC_NR_LEN_BIT] ? 6'(OWC_NR_LONG_CYC) : 6'(OWC_NR_SHORT_CYC); // see R8
    // Anything but the erased code keeps protection on, the safe reading
    wire        prot_d     = (prot_code == OWC_PROT_ON) || (prot_code != 3'h7); // see R11
    wire        sub_sel_d  = word1_q[OWC_SUB_FREQ_BIT]; // see R12
    wire        rc_bad_d   = (rc_sel == OWC_RC_BAD); // see R14
    wire        clk_role_d = word1_q[OWC_CLK_ROLE_BIT]; // see R15
    wire        cyc_out_d  = word1_q[OWC_CYC_OUT_BIT]; // see R16

    // Settings outputs, registered; valid rises with the first settled settings, never before
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            run_q <= 1'b0;
        end else begin
            run_q <= running;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_q <= OWC_WORD0_RST[OWC_START_MODE_BIT];
        end else begin
            mode_q <= mode_d;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_sel_q <= OWC_WORD0_RST[OWC_RST_PIN_BIT];
        end else begin
            pin_sel_q <= pin_sel_d;
        end
    end

    // Watchdog stays off until the words are in, so a stale default never starts it
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wdt_run_q <= 1'b0;
        end else begin
            wdt_run_q <= wdt_run_d;
        end
    end

    // Low-power gating is taken live; the filter drops one cycle after entry
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            nr_on_q <= 1'b0;
        end else begin
            nr_on_q <= nr_on_d;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            nr_min_q <= 6'(OWC_NR_LONG_CYC);
        end else begin
            nr_min_q <= nr_min_d;
        end
    end

    // Protection reads on only in reset; while the words load it follows the erased default 111, which is off
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prot_q <= 1'b1;
        end else begin
            prot_q <= prot_d;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sub_sel_q <= OWC_WORD1_RST[OWC_SUB_FREQ_BIT];
        end else begin
            sub_sel_q <= sub_sel_d;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rc_q <= OWC_RC_8M;
        end else begin
            rc_q <= rc_sel; // see R14
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rc_bad_q <= 1'b0;
        end else begin
            rc_bad_q <= rc_bad_d;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            clk_role_q <= OWC_WORD1_RST[OWC_CLK_ROLE_BIT];
        end else begin
            clk_role_q <= clk_role_d;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cyc_out_q <= OWC_WORD1_RST[OWC_CYC_OUT_BIT];
        end else begin
            cyc_out_q <= cyc_out_d;
        end
    end

    assign options_valid           = run_q;
    assign mirror_ctrl_a           = mir_q[0];
    assign mirror_ctrl_b           = mir_q[1];
    assign mirror_ctrl_c           = mir_q[2];
    assign mir_rdata               = rdata_q;
    assign lowvolt_reset           = lv_q;
    assign watchdog_tick           = wdt_tick_q;
    assign sub_clock_tick          = sub_tick_q;
    assign reset_start_mode_select = mode_q;
    assign reset_pin_select        = pin_sel_q;
    assign watchdog_run            = wdt_run_q;
    assign noise_filter_on         = nr_on_q;
    assign noise_min_cycles        = nr_min_q;
    assign protect_on              = prot_q;
    assign sub_clock_freq_sel      = sub_sel_q;
    assign rc_freq_sel             = rc_q;
    assign rc_freq_invalid         = rc_bad_q;
    assign clock_pin_role_sel      = clk_role_q;
    assign cycle_clock_out_en      = cyc_out_q;
endmodule

/* test/owc_programmer_model.sv */
`timescale 1ns/100ps
module owc_programmer_model (
    // Wanted settings
    input wire logic [14:0] fld0,
    input wire logic [14:0] fld1,
    // Programmed words
    output logic [14:0] opt_word0,
    output logic [14:0] opt_word1
);
    // Unused bits are forced here so a test cannot leave them wrong
    assign opt_word0 = (fld0 & 15'h45FF) | 15'h3800;
    assign opt_word1 = (fld1 & 15'h2063) | 15'h5F9C;
endmodule

/* test/owc_option_latch_asserts.sv */
`timescale 1ns/100ps
module owc_option_latch_chk (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [14:0] opt_word0,
    input wire logic [14:0] opt_word1,
    input wire logic low_power_mode,
    input wire logic options_valid,
    input wire logic [7:0] mirror_ctrl_a,
    input wire logic reset_start_mode_select,
    input wire logic reset_pin_select,
    input wire logic watchdog_run,
    input wire logic noise_filter_on,
    input wire logic [5:0] noise_min_cycles,
    input wire logic protect_on,
    input wire logic [1:0] rc_freq_sel,
    input wire logic rc_freq_invalid
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    property p_src; options_valid && opt_word0[14] |-> mirror_ctrl_a == opt_word0[7:0]; endproperty
    a_src: assert property (p_src) else $error("mirror not from option");
    property p_mode; options_valid |-> reset_start_mode_select == opt_word0[10]; endproperty
    a_mode: assert property (p_mode) else $error("start mode wrong");
    property p_pin; options_valid |-> reset_pin_select == opt_word0[6]; endproperty
    a_pin: assert property (p_pin) else $error("pin select wrong");
    property p_wdt; options_valid |-> watchdog_run == !opt_word0[5]; endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog enable wrong");
    property p_len; options_valid |-> noise_min_cycles == (opt_word0[4] ? 6'h20 : 6'h08); endproperty
    a_len: assert property (p_len) else $error("pulse length wrong");
    property p_nr;
        options_valid && $past(options_valid) |-> noise_filter_on == (opt_word0[3] && !$past(low_power_mode));
    endproperty
    a_nr: assert property (p_nr) else $error("noise filter wrong");
    property p_prot; options_valid |-> protect_on == (opt_word0[2:0] != 3'h7); endproperty
    a_prot: assert property (p_prot) else $error("protect wrong");
    property p_rc;
        options_valid |-> rc_freq_sel == opt_word1[6:5] && rc_freq_invalid == (opt_word1[6:5] == 2'h0);
    endproperty
    a_rc: assert property (p_rc) else $error("rc select wrong");
    property p_hold;
        options_valid && $past(options_valid) |-> $stable({reset_start_mode_select, protect_on, rc_freq_sel});
    endproperty
    a_hold: assert property (p_hold) else $error("options changed");
    c_src0: cover property (options_valid && !opt_word0[14]);
    c_lowp: cover property (options_valid && low_power_mode);
    c_rcbad: cover property (options_valid && rc_freq_invalid);
endmodule
bind owc_option_latch owc_option_latch_chk i_owc_option_latch_chk (.clk, .reset_n, .opt_word0, .opt_word1,
    .low_power_mode, .options_valid, .mirror_ctrl_a, .reset_start_mode_select, .reset_pin_select, .watchdog_run,
    .noise_filter_on, .noise_min_cycles, .protect_on, .rc_freq_sel, .rc_freq_invalid);

/* test/tb_owc_option_latch.sv */
`timescale 1ns/100ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin miscompares++; $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module tb_owc_option_latch;
    import owc_pkg::*;
    logic clk, reset_n, sys_reset, low_power_mode, mir_wr, mir_rd;
    logic [14:0] fld0, fld1, opt_word0, opt_word1;
    logic [3:0] vdd_below;
    logic [1:0] mir_addr, rc_freq_sel;
    logic [7:0] mir_wdata, mir_rdata, mirror_ctrl_a, mirror_ctrl_b, mirror_ctrl_c;
    logic options_valid, reset_start_mode_select, lowvolt_reset, reset_pin_select, watchdog_run;
    logic noise_filter_on, protect_on, sub_clock_freq_sel, sub_clock_tick, watchdog_tick;
    logic rc_freq_invalid, clock_pin_role_sel, cycle_clock_out_en;
    logic [5:0] noise_min_cycles;
    int miscompares, comparisons;
    owc_programmer_model i_owc_programmer_model (.fld0(fld0), .fld1(fld1), .opt_word0(opt_word0),
        .opt_word1(opt_word1));
    owc_option_latch i_owc_option_latch (.*);
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic finish_test;
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic power_on(input logic [14:0] f0, input logic [14:0] f1);
        reset_n <= 1'b0;
        fld0 <= f0;
        fld1 <= f1;
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        repeat (6) @(posedge clk);
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        mir_wr <= 1'b1;
        mir_addr <= a;
        mir_wdata <= d;
        @(posedge clk);
        mir_wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [1:0] a, input logic [7:0] e);
        mir_rd <= 1'b1;
        mir_addr <= a;
        @(posedge clk);
        mir_rd <= 1'b0;
        #1 `CHK(mir_rdata, e)
        @(posedge clk);
    endtask
    // A dip is compared just before it ends, so the short case sits under the limit
    task automatic dip(input logic [3:0] v, input int cyc, input logic e);
        vdd_below <= v;
        repeat (cyc) @(posedge clk);
        #1 `CHK(lowvolt_reset, e)
        @(posedge clk);
        vdd_below <= 4'h0;
        repeat (4) @(posedge clk);
    endtask
    task automatic tick_gap(input bit sub, input int e);
        int n;
        n = 0;
        while (n < 20000 && (sub ? sub_clock_tick : watchdog_tick) !== 1'b1) begin @(posedge clk); #1; n++; end
        n = 0;
        do begin @(posedge clk); #1; n++; end while (n < 20000 && (sub ? sub_clock_tick : watchdog_tick) !== 1'b1);
        `CHK(n, e)
        @(posedge clk);
    endtask
    initial begin
        #300000;
        miscompares++;
        finish_test();
    end
    initial begin
        reset_n = 1'b0; sys_reset = 1'b0; low_power_mode = 1'b0; vdd_below = 4'h0;
        mir_addr = 2'h0; mir_wdata = 8'h00; mir_wr = 1'b0; mir_rd = 1'b0; fld0 = 15'h0; fld1 = 15'h0;
        miscompares = 0;
        comparisons = 0;
        power_on(15'h445F, 15'h2041);
        `CHK(mirror_ctrl_c, 8'h7C)
        `CHK(reset_start_mode_select, 1'b1)
        `CHK(reset_pin_select, 1'b1)
        `CHK(watchdog_run, 1'b1)
        `CHK(noise_min_cycles, 6'h20)
        `CHK(noise_filter_on, 1'b1)
        `CHK(protect_on, 1'b0)
        `CHK(sub_clock_freq_sel, 1'b1)
        `CHK(rc_freq_sel, OWC_RC_16M)
        `CHK(clock_pin_role_sel, 1'b0)
        `CHK(cycle_clock_out_en, 1'b1)
        wr(OWC_MIR_A, 8'hAA);
        `CHK(mirror_ctrl_a, 8'h5F)
        low_power_mode <= 1'b1;
        repeat (2) @(posedge clk);
        `CHK(noise_filter_on, 1'b0)
        low_power_mode <= 1'b0;
        sys_reset <= 1'b1;
        repeat (4) @(posedge clk);
        sys_reset <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK(options_valid, 1'b1)
        `CHK(mirror_ctrl_a, 8'h5F)
        dip(4'h1, 1000, 1'b0);
        dip(4'h1, 1300, 1'b1);
        dip(4'h6, 1300, 1'b0);
        power_on(15'h01A0, 15'h0002);
        `CHK(mirror_ctrl_a, 8'hA0)
        `CHK(mirror_ctrl_b, 8'h9E)
        `CHK(reset_start_mode_select, 1'b0)
        `CHK(reset_pin_select, 1'b0)
        `CHK(watchdog_run, 1'b0)
        `CHK(noise_min_cycles, 6'h08)
        `CHK(noise_filter_on, 1'b0)
        `CHK(protect_on, 1'b1)
        `CHK(sub_clock_freq_sel, 1'b0)
        `CHK(rc_freq_invalid, 1'b1)
        `CHK(clock_pin_role_sel, 1'b1)
        `CHK(cycle_clock_out_en, 1'b0)
        wr(OWC_MIR_A, 8'h55);
        wr(OWC_MIR_B, 8'h66);
        wr(2'h3, 8'h77);
        rd(OWC_MIR_A, 8'h55);
        rd(OWC_MIR_B, 8'h66);
        rd(OWC_MIR_C, 8'h39);
        rd(2'h3, 8'h00);
        `CHK(mirror_ctrl_a, 8'h55)
        dip(4'hF, 1300, 1'b0);
        tick_gap(1'b0, OWC_WDT_DIV);
        tick_gap(1'b1, OWC_SUB64_DIV);
        power_on(15'h411A, 15'h0020);
        `CHK(rc_freq_sel, OWC_RC_8M)
        `CHK(protect_on, 1'b1)
        dip(4'h4, 1300, 1'b1);
        dip(4'h3, 1300, 1'b0);
        finish_test();
    end
endmodule
